/* logic/forward_queue_status.sv */
`timescale 1ns/1ps
module forward_queue_status import fwd_queue_pkg::*; (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        regAddr,
  input  wire logic              regRead,
  output logic      [15:0]       regRdata,
  input  wire logic              flagClear,
  input  wire logic [8:0]        txForwardThreshold,
  input  wire logic              otpCheckDone,
  input  wire logic              otpCheckPass,
  output logic                   normalState,
  output logic                   porFlag,
  input  wire logic              cmdValid,
  input  wire logic [WORD_W-1:0] cmdWord,
  input  wire logic              cmdLast,
  input  wire logic              forwardWriteChecked,
  input  wire logic              crcOk,
  input  wire logic              crcBad,
  input  wire logic [8:0]        txFifoLevel,
  output logic                   cmdReady,
  input  wire logic              linkReady,
  output logic                   linkValid,
  output logic      [WORD_W-1:0] linkWord,
  input  wire logic              rxPush,
  input  wire logic [WORD_W:0]   rxPushWord,
  input  wire logic              rxPop,
  output logic      [WORD_W-1:0] rxPopWord
);
  // ==========================================
  // Receive FIFO with parity per entry
  logic [WORD_W:0]  rxMem [RX_DEPTH];
  logic [RX_AW-1:0] rxWrPtr;
  logic [RX_AW-1:0] rxRdPtr;
  logic [RX_AW:0]   rxCount;
  logic             rxOverflow;
  logic             rxUnderflow;
  logic             rxSingleErr;
  wire              rxFull     = (rxCount == (RX_AW+1)'(RX_DEPTH));
  wire              rxEmpty    = (rxCount == '0);
  wire              rxDoPush   = rxPush && !rxFull;
  wire              rxDoPop    = rxPop && !rxEmpty;
  wire [WORD_W:0]   rxHead     = rxMem[rxRdPtr];
  wire              rxParErr   = rxDoPop && (^rxHead);
  wire [7:0]        rxLevel    = (rxCount >= (RX_AW+1)'(RX_LEVEL_SAT)) ? RX_LEVEL_SAT : rxCount[7:0];
  wire [15:0]       statusWord = {rxOverflow, rxUnderflow, rxSingleErr, 5'h00, rxLevel};
  wire              statusHit  = regRead && (regAddr == RX_STATUS_ADDR);

  always_ff @(posedge clk) begin
    if (rxDoPush) rxMem[rxWrPtr] <= rxPushWord;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxWrPtr   <= '0;
      rxRdPtr   <= '0;
      rxCount   <= '0;
      rxPopWord <= '0;
    end else begin
      if (rxDoPush) rxWrPtr <= rxWrPtr + 1'b1;
      if (rxDoPop) rxRdPtr <= rxRdPtr + 1'b1;
      if (rxDoPop) rxPopWord <= rxHead[WORD_W-1:0];
      rxCount <= rxCount + (RX_AW+1)'(rxDoPush) - (RX_AW+1)'(rxDoPop);
    end
  end

  // ==========================================
  // Sticky flags, set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxOverflow  <= 1'b0;
      rxUnderflow <= 1'b0;
      rxSingleErr <= 1'b0;
      porFlag     <= POR_FLAG_RESET;
    end else begin
      rxOverflow  <= (rxPush && rxFull) || (rxOverflow && !flagClear);
      rxUnderflow <= (rxPop && rxEmpty) || (rxUnderflow && !flagClear);
      rxSingleErr <= rxParErr || (rxSingleErr && !flagClear);
      porFlag     <= porFlag && !flagClear;
    end
  end

  // ==========================================
  // Register read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= RX_STATUS_RESET;
    end else begin
      // level and flags, no clear on read
      regRdata <= statusHit ? statusWord : 16'h0000;
    end
  end

  // ==========================================
  // Power-up qualification
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      normalState <= 1'b0;
    end else if (otpCheckDone && otpCheckPass) begin
      normalState <= 1'b1;
    end
  end

  // ==========================================
  // Command queue and forwarding gate
  word_fifo_if #(.W(WORD_W)) qIn ();
  word_fifo_if #(.W(WORD_W)) qOut ();
  fwd_state_e fwdState;
  fwd_state_e next_fwdState;
  assign qIn.valid = cmdValid;
  assign qIn.data  = cmdWord;
  wire   fwdAllowed = normalState && !porFlag;
  wire   threshMet  = (txFifoLevel >= txForwardThreshold) || cmdLast;
  wire   sendBeat   = (fwdState == FWD_SEND) && qOut.valid && (!linkValid || linkReady);
  assign qOut.ready = sendBeat;

  word_fifo #(.WIDTH(WORD_W), .DEPTH(QUEUE_DEPTH)) cmdQueue (
    .clk     (clk),
    .nrst    (nrst),
    .inPort  (qIn),
    .outPort (qOut)
  );

  always_comb begin
    next_fwdState = fwdState;
    unique case (fwdState)
      FWD_IDLE: begin
        if (fwdAllowed && qOut.valid) begin
          if (forwardWriteChecked) next_fwdState = FWD_CHECK;
          else if (threshMet) next_fwdState = FWD_SEND;
        end
      end
      FWD_CHECK: begin
        if (crcOk) next_fwdState = FWD_SEND;
        else if (crcBad) next_fwdState = FWD_IDLE;
      end
      FWD_SEND: begin
        if (!qOut.valid) next_fwdState = FWD_IDLE;
      end
      default: next_fwdState = FWD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fwdState    <= FWD_IDLE;
      cmdReady    <= 1'b0;
      linkValid   <= 1'b0;
      linkWord    <= '0;
    end else begin
      fwdState    <= next_fwdState;
      cmdReady    <= qIn.ready && !(cmdValid && qIn.ready);
      if (sendBeat) begin
        linkValid <= 1'b1;
        linkWord  <= qOut.data;
      end else if (linkReady) begin
        linkValid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Checks
  AST_POR_BLOCKS: assert property (@(posedge clk) disable iff (!nrst)
    porFlag |-> !sendBeat) else $error("forwarding while power-on flag set");
  AST_POR_STICKY: assert property (@(posedge clk) disable iff (!nrst)
    $fell(porFlag) |-> $past(flagClear)) else $error("power-on flag dropped without clear");
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!nrst)
    (rxPush && rxFull) |=> rxOverflow) else $error("overflow not flagged");
  AST_UVF_SET: assert property (@(posedge clk) disable iff (!nrst)
    (rxPop && rxEmpty) |=> rxUnderflow) else $error("underflow not flagged");
  AST_SED_SET: assert property (@(posedge clk) disable iff (!nrst)
    rxParErr |=> rxSingleErr) else $error("single error not flagged");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (rxOverflow && !flagClear) |=> rxOverflow) else $error("overflow flag lost");
  AST_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
    statusHit |=> regRdata[7:0] == (($past(rxCount) >= 9'd255) ? 8'hff : $past(rxCount[7:0])))
    else $error("level mismatch");
  AST_RESV_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    regRdata[12:8] == 5'h00) else $error("reserved bits set");
  AST_CHECK_WAIT: assert property (@(posedge clk) disable iff (!nrst)
    (fwdState == FWD_CHECK && !crcOk) |=> fwdState != FWD_SEND) else $error("sent before crc");
  AST_NORMAL: assert property (@(posedge clk) disable iff (!nrst)
    $rose(normalState) |-> $past(otpCheckPass)) else $error("normal without pass");
endmodule

/* logic/fwd_queue_pkg.sv */
package fwd_queue_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0]  RX_STATUS_ADDR   = 8'h0a;
  localparam logic [15:0] RX_STATUS_RESET  = 16'h0000;
  localparam int          RX_OVF_BIT       = 15;
  localparam int          RX_UVF_BIT       = 14;
  localparam int          RX_SED_BIT       = 13;
  localparam logic [7:0]  RX_LEVEL_SAT     = 8'hff;
  localparam int          RX_DEPTH         = 256;
  localparam int          RX_AW            = 8;
  // ==========================================
  // Forwarding path
  localparam int          WORD_W           = 16;
  localparam int          QUEUE_DEPTH      = 4;
  localparam logic [8:0]  TX_THRESH_RESET  = 9'h014;
  localparam logic        POR_FLAG_RESET   = 1'b1;
  typedef enum logic [1:0] {
    FWD_IDLE  = 2'b00,
    FWD_CHECK = 2'b01,
    FWD_SEND  = 2'b10
  } fwd_state_e;
endpackage

/* logic/word_fifo_if.sv */
`timescale 1ns/1ps
interface word_fifo_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* logic/word_fifo.sv */
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic nrst,
  word_fifo_if.sink   inPort,
  word_fifo_if.source outPort
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doWrite = inPort.valid && inPort.ready;
  wire              doRead  = outPort.valid && outPort.ready;
  assign inPort.ready  = (count != (AW+1)'(DEPTH));
  assign outPort.valid = (count != '0);
  assign outPort.data  = mem[rdPtr];
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inPort.data;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead) rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

/* bench/link_sink.sv */
`timescale 1ns/1ps
// ==========================================
// Driver chain end of the link, records words
module link_sink (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        linkValid,
  input  wire logic [15:0] linkWord,
  output logic             linkReady
);
  logic [15:0] got[$];
  assign linkReady = !stall;
  always @(posedge clk) begin
    if (linkValid && linkReady) begin
      got.push_back(linkWord);
    end
  end
endmodule

/* bench/forward_queue_status_tb_top.sv */
`timescale 1ns/1ps
module forward_queue_status_tb_top import fwd_queue_pkg::*;;
  logic clk, nrst, regRead, flagClear, otpCheckDone, otpCheckPass, cmdValid, cmdLast, fwc, crcOk, crcBad;
  logic rxPush, rxPop, linkReady, linkValid, porFlag, normalState, stall;
  logic [7:0]  regAddr;
  logic [8:0]  thr, txLvl;
  logic [15:0] regRdata, cmdWord, linkWord, rxPopWord;
  logic [16:0] rxPushWord;
  int          n_errors, checked;
  forward_queue_status u_forward_queue_status (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regRead(regRead),
    .regRdata(regRdata), .flagClear(flagClear), .txForwardThreshold(thr), .otpCheckDone(otpCheckDone),
    .otpCheckPass(otpCheckPass), .normalState(normalState), .porFlag(porFlag), .cmdValid(cmdValid),
    .cmdWord(cmdWord), .cmdLast(cmdLast), .forwardWriteChecked(fwc), .crcOk(crcOk), .crcBad(crcBad),
    .txFifoLevel(txLvl), .cmdReady(), .linkReady(linkReady), .linkValid(linkValid), .linkWord(linkWord),
    .rxPush(rxPush), .rxPushWord(rxPushWord), .rxPop(rxPop), .rxPopWord(rxPopWord));
  link_sink u_link_sink (.clk(clk), .stall(stall), .linkValid(linkValid), .linkWord(linkWord),
    .linkReady(linkReady));
  // ==========================================
  // Helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task rd(input logic [15:0] e);
    regAddr = RX_STATUS_ADDR; regRead = 1'b1; cyc(1); regRead = 1'b0; chk(regRdata, e); cyc(1);
  endtask
  task push(input logic [15:0] w, input logic bad);
    rxPush = 1'b1; rxPushWord = {^w ^ bad, w}; cyc(1); rxPush = 1'b0; cyc(1);
  endtask
  task pop;
    rxPop = 1'b1; cyc(1); rxPop = 1'b0; cyc(1);
  endtask
  task cmd(input logic [15:0] w, input logic last);
    cmdValid = 1'b1; cmdWord = w; cmdLast = last; cyc(1); cmdValid = 1'b0; cyc(1);
  endtask
  task waitGot(input int n);
    for (int i = 0; i < 30 && u_link_sink.got.size() < n; i++) cyc(1);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    n_errors++;
    conclude();
  end
  // ==========================================
  // Tests
  initial begin
    {nrst, regRead, flagClear, otpCheckDone, otpCheckPass, cmdValid, cmdLast, fwc, crcOk, crcBad} = '0;
    {rxPush, rxPop, stall, regAddr, cmdWord, rxPushWord} = '0;
    thr = 9'h014; txLvl = '0; n_errors = 0; checked = 0;
    cyc(12);
    nrst = 1'b1;
    cyc(1);
    rd(16'h0000);
    chk(porFlag, 1);
    otpCheckDone = 1'b1; cyc(3); chk(normalState, 0);
    otpCheckPass = 1'b1; cyc(3); chk(normalState, 1);
    $display("test reset done");
    cmd(16'h00a5, 1'b1); cyc(6); chk(u_link_sink.got.size(), 0);
    txLvl = 9'h014;
    flagClear = 1'b1; cyc(1); flagClear = 1'b0; waitGot(1); chk(porFlag, 0);
    chk(u_link_sink.got[0], 16'h00a5);
    thr = 9'h014; txLvl = 9'h014; fwc = 1'b1;
    cmd(16'h0c3c, 1'b0); cyc(6); chk(u_link_sink.got.size(), 1);
    crcBad = 1'b1; cyc(1); crcBad = 1'b0; cyc(5); chk(u_link_sink.got.size(), 1);
    crcOk = 1'b1; cyc(1); crcOk = 1'b0; waitGot(2); chk(u_link_sink.got[1], 16'h0c3c);
    fwc = 1'b0; stall = 1'b1;
    for (int i = 0; i < 4; i++) cmd(16'h0100 + 16'(i), 1'b0);
    stall = 1'b0; waitGot(6);
    for (int i = 0; i < 4; i++) chk(u_link_sink.got[2+i], 16'h0100 + 16'(i));
    $display("test forward done");
    push(16'h1234, 1'b0); rd(16'h0001);
    pop(); chk(rxPopWord, 16'h1234); rd(16'h0000);
    pop(); rd(16'h4000);
    push(16'h5a5a, 1'b1); pop(); rd(16'h6000); rd(16'h6000);
    flagClear = 1'b1; cyc(1); flagClear = 1'b0; cyc(1); rd(16'h0000);
    for (int i = 0; i < 254; i++) push(16'(i), 1'b0);
    rd(16'h00fe);
    push(16'h0, 1'b0); rd(16'h00ff); push(16'h0, 1'b0); rd(16'h00ff);
    push(16'h0, 1'b0); rd(16'h80ff); rd(16'h80ff);
    pop(); chk(rxPopWord, 16'h0000); rd(16'h80ff);
    $display("test rx done");
    conclude();
  end
endmodule
